// ==== rtl/dhs_pkg.sv ====
`default_nettype none
package dhs_pkg;
  // ------------------------------------------------------------
  // word layout
  // ------------------------------------------------------------
  localparam int WORD_W        = 16;
  localparam int SEL_POS       = 11;
  localparam int ADDR_RST_POS  = 9;
  localparam int DESC_BYTES    = 57;
  localparam int DESC_BITS     = 456;
  localparam int PTR_W         = 6;
  localparam logic [WORD_W-1:0] ZERO_MASK = 16'hf500;
  // ------------------------------------------------------------
  // descriptor field offsets
  // ------------------------------------------------------------
  localparam int OFS_VENDOR_ID  = 0;
  localparam int OFS_PRODUCT_ID = 2;
  localparam int OFS_PROD_STR   = 4;
  localparam int OFS_VEND_STR   = 20;
  localparam int OFS_POWER_ATTR = 52;
  localparam int OFS_MAX_POWER  = 53;
  localparam int OFS_AUX_USAGE  = 54;
  localparam logic [7:0] HID_RESET = 8'h00;
  localparam logic [7:0] DESC_RESET = 8'h00;

  typedef enum logic [1:0] {
    DHS_STATUS     = 2'b00,
    DHS_STATUS_RST = 2'b01,
    DHS_DATA       = 2'b10,
    DHS_RESERVED   = 2'b11
  } dhs_cmd_t;

  typedef struct packed {
    logic mute;
    logic vol_up;
    logic vol_down;
    logic next_track;
    logic prev_track;
    logic stop;
    logic play_pause;
    logic ext_cmd;
  } dhs_hid_t;
endpackage : dhs_pkg
`default_nettype wire

// ==== rtl/dhs_serial_port.sv ====
// Behaviour
// - Word bit 11 selects whether the low byte is status or a descriptor byte.
// - A status word drives the eight active-high status outputs, bit 7 mute down to bit 0 extended.
// - A data word stores its byte, D0 as lsb, at the next descriptor position.
// - An address-reset word clears the descriptor byte counter for a fresh image.
// - Codes 00 status, 01 status plus counter reset, 10 data, 11 reserved.
// - The image is 57 bytes: ids, product string, vendor string, power, aux usage.
// - Strings are kept as one-byte characters, widened on the way out.
`default_nettype none
module dhs_serial_port #(
  parameter int DEPTH = dhs_pkg::DESC_BYTES
) (
  // system
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // link pins
  input  wire logic            program_shift_clock,
  input  wire logic            program_select,
  input  wire logic            program_data_in,
  // descriptor read port for the usb engine
  input  wire logic [5:0]      desc_rd_addr,
  output logic      [7:0]      desc_rd_data,
  // status toward the usb engine
  output dhs_pkg::dhs_hid_t    hid_status,
  output logic                 desc_done,
  output logic      [5:0]      desc_count,
  output logic                 word_seen,
  output logic      [15:0]     last_word
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // d0 travels first, so each byte lands mirrored in the word
  function automatic logic [7:0] bit_rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      bit_rev[i] = v[7-i];
    end
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] sck_sync_ff;
  logic [1:0] sel_sync_ff;
  logic [1:0] din_sync_ff;
  logic       sck_d_ff;
  logic       sel_d_ff;

  // shift clock parks low, so a low reset value gives no false rise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_sync_ff <= 2'h0;
      sck_d_ff    <= 1'b0;
    end else begin
      sck_sync_ff <= {sck_sync_ff[0], program_shift_clock};
      sck_d_ff    <= sck_sync_ff[1];
    end
  end

  // select idles high; reset high so no frame end is seen after reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_sync_ff <= 2'h3;
      sel_d_ff    <= 1'b1;
    end else begin
      sel_sync_ff <= {sel_sync_ff[0], program_select};
      sel_d_ff    <= sel_sync_ff[1];
    end
  end

  // data passes as many stages as the clock, so it stays aligned with its edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      din_sync_ff <= 2'h0;
    end else begin
      din_sync_ff <= {din_sync_ff[0], program_data_in};
    end
  end

  logic sck_rise;
  logic sel_rise;
  logic sel_low;
  assign sck_rise = sck_sync_ff[1] & ~sck_d_ff;
  assign sel_rise = sel_sync_ff[1] & ~sel_d_ff;
  assign sel_low  = ~sel_sync_ff[1];

  // ------------------------------------------------------------
  // shifter
  // ------------------------------------------------------------
  logic [15:0] shift_ff;
  logic [4:0]  nbits_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_ff <= 16'h0000;
    end else if (!sel_d_ff && sck_rise && sel_low) begin
      shift_ff <= {shift_ff[14:0], din_sync_ff[1]};
    end
  end

  // count saturates at sixteen: extra bits keep only the last sixteen
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nbits_ff <= 5'h00;
    end else if (sel_d_ff) begin
      nbits_ff <= 5'h00;
    end else if (sck_rise && sel_low && (nbits_ff != 5'h10)) begin
      nbits_ff <= nbits_ff + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // word decode
  // ------------------------------------------------------------
  // a short frame is dropped at the select rise
  logic              word_ok;
  dhs_pkg::dhs_cmd_t cmd;
  logic [7:0]        low_byte;
  logic              status_take;
  logic              addr_clear;
  logic              data_take;
  logic              done_ff;

  assign word_ok  = sel_rise && (nbits_ff == 5'h10);
  assign cmd      = dhs_pkg::dhs_cmd_t'({shift_ff[dhs_pkg::SEL_POS],
                                         shift_ff[dhs_pkg::ADDR_RST_POS]});
  assign low_byte = bit_rev(shift_ff[7:0]);

  always_comb begin
    status_take = 1'b0;
    addr_clear  = 1'b0;
    data_take   = 1'b0;
    if (word_ok) begin
      case (cmd)
        dhs_pkg::DHS_STATUS: begin
          status_take = 1'b1;
        end
        dhs_pkg::DHS_STATUS_RST: begin
          status_take = 1'b1;
          addr_clear  = 1'b1;
        end
        dhs_pkg::DHS_DATA: begin
          // bytes past a full image are dropped until the next address reset
          data_take = !done_ff;
        end
        default: begin
          status_take = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // status bits
  // ------------------------------------------------------------
  dhs_pkg::dhs_hid_t hid_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hid_ff <= dhs_pkg::dhs_hid_t'(dhs_pkg::HID_RESET);
    end else if (status_take) begin
      hid_ff <= dhs_pkg::dhs_hid_t'(low_byte);
    end
  end

  assign hid_status = hid_ff;

  // ------------------------------------------------------------
  // descriptor store
  // ------------------------------------------------------------
  logic [7:0] desc_mem [DEPTH];
  logic [5:0] ptr_ff;

  // pointer stops on the last byte; the done flag marks a full image
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ptr_ff <= 6'h00;
    end else if (addr_clear) begin
      ptr_ff <= 6'h00;
    end else if (data_take && (ptr_ff != 6'(DEPTH - 1))) begin
      ptr_ff <= ptr_ff + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else if (addr_clear) begin
      done_ff <= 1'b0;
    end else if (data_take && (ptr_ff == 6'(DEPTH - 1))) begin
      done_ff <= 1'b1;
    end
  end

  // no reset on the store: contents are only trusted once done
  // strings kept one byte a character; widening happens in the usb engine
  always_ff @(posedge clk_sys) begin
    if (data_take) begin
      desc_mem[ptr_ff] <= low_byte;
    end
  end

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  logic [7:0]  rd_data_ff;
  logic [5:0]  count_ff;
  logic        seen_ff;
  logic [15:0] last_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_ff <= dhs_pkg::DESC_RESET;
    end else begin
      rd_data_ff <= (desc_rd_addr < 6'(DEPTH)) ? desc_mem[desc_rd_addr] : 8'h00;
    end
  end

  // count lags the done flag by one cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_ff <= 6'h00;
    end else begin
      count_ff <= done_ff ? 6'(DEPTH) : ptr_ff;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= word_ok;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_ff <= 16'h0000;
    end else if (word_ok) begin
      last_ff <= shift_ff & ~dhs_pkg::ZERO_MASK;
    end
  end

  assign desc_rd_data = rd_data_ff;
  assign desc_count   = count_ff;
  assign desc_done    = done_ff;
  assign word_seen    = seen_ff;
  assign last_word    = last_ff;
endmodule // dhs_serial_port
`default_nettype wire

// ==== sim/dhs_asserts.sv ====
`default_nettype none
module dhs_asserts #(parameter int DEPTH = 57) (
  input wire logic          clk_sys, rst, word_seen, desc_done,
  input wire logic          program_shift_clock, program_select, program_data_in,
  input wire logic [5:0]    desc_rd_addr, desc_count,
  input wire logic [7:0]    desc_rd_data,
  input wire logic [15:0]   last_word,
  input wire dhs_pkg::dhs_hid_t hid_status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rv;
  // d0 travels first, so the low byte arrives mirrored
  always_comb for (int i = 0; i < 8; i++) rv[i] = last_word[7-i];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_seen_pulse: assert property (word_seen |=> !word_seen) else $error("pulse");
  chk_seen_frame: assert property (word_seen |-> $past(program_select, 2)) else $error("frame");
  chk_status_value: assert property (word_seen && !last_word[11] |-> ##[0:1] hid_status == rv)
    else $error("status");
  chk_data_keeps: assert property (word_seen && last_word[11] |-> $stable(hid_status) ##1
    $stable(hid_status)) else $error("hid moved");
  chk_addr_clear: assert property (word_seen && last_word[11:8] == 4'h2 |-> ##[0:1]
    desc_count == 6'd0) else $error("clear");
  chk_count_step: assert property (!$stable(desc_count) |-> desc_count == 6'd0 ||
    desc_count == $past(desc_count) + 6'd1) else $error("step");
  chk_done_full: assert property (desc_done && $past(desc_done) |-> desc_count == DEPTH)
    else $error("done");
  chk_zero_bits: assert property ((last_word & dhs_pkg::ZERO_MASK) == 16'h0000) else $error("z");
  chk_rsvd_idle: assert property (word_seen && last_word[11:9] == 3'h5 |-> $stable(desc_count)
    ##1 $stable(desc_count)) else $error("reserved");
  chk_read_range: assert property (desc_rd_addr >= DEPTH |=> desc_rd_data == 8'h00)
    else $error("range");
  cover property (word_seen && !last_word[11]);
  cover property (word_seen && last_word[11]);
  cover property ($rose(desc_done));
endmodule // dhs_asserts
bind dhs_serial_port dhs_asserts #(.DEPTH(DEPTH)) u_chk (.*);
`default_nettype wire

// ==== sim/dhs_ctl_model.sv ====
`default_nettype none
module dhs_ctl_model (
  output logic program_shift_clock = 1'b0,
  output logic program_select      = 1'b1,
  output logic program_data_in     = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock parked low between frames; stale data is flipped so it never looks valid
  task automatic send(input logic [15:0] w, input int n);
    program_select = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      program_data_in = w[i];
      #160 program_shift_clock = 1'b1;
      #160 program_shift_clock = 1'b0;
    end
    #160 program_select = 1'b1;
    program_data_in = ~program_data_in;
    #400;
  endtask
endmodule // dhs_ctl_model
`default_nettype wire

// ==== sim/tb.sv ====
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH %0t %h", $time, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [5:0] desc_rd_addr = 6'h00;
  wire logic program_shift_clock, program_select, program_data_in, word_seen, desc_done;
  wire logic [5:0] desc_count;
  wire logic [7:0] desc_rd_data;
  wire logic [15:0] last_word;
  wire dhs_pkg::dhs_hid_t hid_status;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #20 clk_sys = ~clk_sys;
  dhs_serial_port u_dut (.*);
  dhs_ctl_model u_ctl (.*);
  function automatic logic [7:0] rv(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rv[i] = b[7-i];
  endfunction
  // power bytes must match the supply the board really has
  function automatic logic [7:0] img(input int k);
    if (k == dhs_pkg::OFS_POWER_ATTR) img = 8'h80;
    else if (k == dhs_pkg::OFS_MAX_POWER) img = 8'h7d;
    else img = 8'h30 + k[7:0];
  endfunction
  logic dplus_pullup = 1'b0;
  task automatic wr(input logic [15:0] w, input int n = 16);
    @(posedge clk_sys);
    #1 u_ctl.send(w, n);
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000 n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst = 1'b0;
    `CHK(hid_status, 8'h00)
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      wr({8'h00, rv(8'h01 << i)});
      `CHK(hid_status, 8'h01 << i)
    end
    wr({8'h02, rv(8'ha5)});
    `CHK(desc_count, 6'd0)
    `CHK(hid_status, 8'ha5)
    // one byte past the image must be dropped
    for (int k = 0; k < 58; k++) wr({8'h08, rv(img(k))});
    `CHK(desc_count, 6'd57)
    `CHK(desc_done, 1'b1)
    `CHK(hid_status, 8'ha5)
    for (int k = 0; k < 58; k++) begin
      desc_rd_addr = k[5:0];
      repeat (2) @(posedge clk_sys);
      #1 `CHK(desc_rd_data, k < dhs_pkg::DESC_BYTES ? img(k) : 8'h00)
    end
    dplus_pullup = desc_done;
    wr({8'h0a, rv(8'hff)});
    wr(16'hf03c, 12);
    `CHK(hid_status, 8'ha5)
    `CHK(desc_count, 6'd57)
    wr(16'hf500 | rv(8'h3c));
    `CHK(hid_status, 8'h3c)
    `CHK(last_word, {8'h00, rv(8'h3c)})
    dplus_pullup = 1'b0;
    wr({8'h02, rv(8'h00)});
    `CHK(hid_status, 8'h00)
    wr({8'h08, rv(8'h5a)});
    `CHK(desc_count, 6'd1)
    `CHK(desc_done, 1'b0)
    complete_run;
  end
endmodule // tb
`default_nettype wire
